// file: hw/rwx_pkg.sv
/*
 package of constants and types for the return / idle / watchdog-clear execution unit.
 assumes an 8-bit core with a byte-wide stack in data memory and 16-bit pc.
*/
// Functional notes
// - interrupt return resumes the interrupted program
// - interrupt return re-enables global interrupts automatically
// - idle changes nothing but advances pc
// - watchdog clear restarts watchdog count
// - none of these four touch flags
package rwx_pkg;
   localparam int  PC_W        = 16;
   localparam int  SP_W        = 8;
   localparam int  FLAG_W      = 4;
   localparam int  OPC_W       = 3;
   localparam int  STACK_DEPTH = 256;
   localparam logic [SP_W-1:0]  SP_RESET    = 8'h00;
   localparam logic [PC_W-1:0]  PC_RESET    = 16'h0000;
   localparam logic [SP_W-1:0]  SP_POP_STEP = 8'h02;
   localparam logic [PC_W-1:0]  PC_STEP     = 16'h0001;
   localparam logic [FLAG_W-1:0] FLAG_RESET = 4'h0;
   // flag field positions
   localparam int  FLAG_ZERO_POS   = 0;
   localparam int  FLAG_BORROW_POS = 1;
   localparam int  FLAG_HALF_POS   = 2;
   localparam int  FLAG_SIGNED_POS = 3;

   typedef enum logic [OPC_W-1:0] {
      RWX_OP_NONE     = 3'h0,
      RWX_OP_CALLEXIT = 3'h1,
      RWX_OP_ISREXIT  = 3'h2,
      RWX_OP_IDLE     = 3'h3,
      RWX_OP_WDCLEAR  = 3'h4
   } rwx_op_t;

   typedef enum logic [3:0] {
      RWX_ST_READY = 4'h1,
      RWX_ST_LOW   = 4'h2,
      RWX_ST_HIGH  = 4'h4,
      RWX_ST_DONE  = 4'h8
   } rwx_state_t;
endpackage : rwx_pkg

// file: hw/rwx_stack_mem.sv
/*
 byte-wide stack memory with registered read data.
 assumes single clock; write and read addresses independent.
*/
`timescale 1ns/1ps
module rwx_stack_mem #(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic          clock,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [7:0]    rd_data
);
   logic [7:0] mem [DEPTH];

   // no reset on the array; read data stays undefined until the address read has been written
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : rwx_stack_mem

// file: hw/rwx_exec.sv
/*
 executes the subroutine return, interrupt return, idle and watchdog-clear
 instructions of a small 8-bit core.
 assumes the decoder presents one op with op_valid for one cycle while ready,
 and that pushes (calls, interrupt entry) arrive through push_* in other cycles.
*/
`timescale 1ns/1ps
module rwx_exec
   import rwx_pkg::*;
#(
   parameter int DEPTH = rwx_pkg::STACK_DEPTH
) (
   input  wire logic                      clock,
   input  wire logic                      rstn,
   input  wire logic                      op_valid,
   input  wire rwx_pkg::rwx_op_t          op,
   input  wire logic                      push_en,
   input  wire logic [7:0]                push_data,
   input  wire logic [rwx_pkg::FLAG_W-1:0] flags_in,
   input  wire logic                      gie_clear,
   output logic                           ready,
   output logic                           done,
   output logic [rwx_pkg::PC_W-1:0]       pc,
   output logic [rwx_pkg::SP_W-1:0]       sp,
   output logic [rwx_pkg::FLAG_W-1:0]     flags,
   output logic                           gie,
   output logic                           wdt_clear
);
   import rwx_pkg::*;

   // sequencing group: where a return stands and what it has read so far
   rwx_state_t           state;
   rwx_state_t           next_state;
   logic                 next_ready;
   logic                 next_done;
   logic                 is_isr;
   logic                 next_is_isr;
   logic [7:0]           pc_low;
   logic [7:0]           next_pc_low;

   // pointer group
   logic [PC_W-1:0]      next_pc;
   logic [SP_W-1:0]      next_sp;

   // side-effect group
   logic                 next_gie;
   logic                 next_wdt_clear;
   logic [FLAG_W-1:0]    next_flags;

   // shared decode of what is taken this cycle
   logic                 push_take;
   logic                 op_take;
   logic                 ret_take;
   logic                 step_take;
   logic                 ret_finish;

   // stack port
   logic                 mem_wr_en;
   logic [SP_W-1:0]      rd_addr;
   logic [7:0]           rd_data;

   function automatic logic [SP_W-1:0] sp_add(input logic [SP_W-1:0] a, input logic [SP_W-1:0] b);
      sp_add = SP_W'(a + b);
   endfunction : sp_add

   function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] a);
      pc_step = PC_W'(a + PC_STEP);
   endfunction : pc_step

   // both returns share one pop sequence
   function automatic logic is_return(input rwx_op_t o);
      is_return = (o == RWX_OP_CALLEXIT) || (o == RWX_OP_ISREXIT);
   endfunction : is_return

   // ops that finish in their own slot and step the pc; watchdog clear also pulses wdt_clear
   function automatic logic is_single(input rwx_op_t o);
      is_single = (o == RWX_OP_IDLE) || (o == RWX_OP_WDCLEAR);
   endfunction : is_single

   // ready is high only in READY, so it alone gates what is taken;
   // whatever is offered while ready is low is dropped without a trace
   always_comb begin
      push_take  = ready && push_en;
      op_take    = ready && op_valid && !push_en;
      ret_take   = op_take && is_return(op);
      step_take  = op_take && is_single(op);
      ret_finish = (state == RWX_ST_DONE);
      mem_wr_en  = push_take;
   end

   rwx_stack_mem #(
      .DEPTH(DEPTH),
      .AW   (SP_W)
   ) u_mem (
      .clock  (clock),
      .wr_en  (mem_wr_en),
      .wr_addr(sp),
      .wr_data(push_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // read at the decremented sp on the taking edge, so [sp] is there in LOW;
   // sp+1 is then held through HIGH so [sp+1] still stands in DONE.
   // two extra cycles bought instead of a second read port
   always_comb begin
      case (state)
         RWX_ST_LOW, RWX_ST_HIGH: begin
            rd_addr = sp_add(sp, SP_W'(1));
         end
         default: begin
            rd_addr = sp_add(sp, SP_W'(-SP_POP_STEP));
         end
      endcase
   end

   always_comb begin
      next_state  = state;
      next_ready  = 1'b0;
      next_done   = 1'b0;
      next_is_isr = is_isr;
      next_pc_low = pc_low;
      case (state)
         RWX_ST_READY: begin
            // also the first cycle after reset; ready rises one edge later
            next_ready = !ret_take;
            if (ret_take) begin
               next_is_isr = (op == RWX_OP_ISREXIT);
               next_state  = RWX_ST_LOW;
            end
            if (step_take) begin
               next_done = 1'b1;
            end
         end
         RWX_ST_LOW: begin
            // low byte of the return address
            next_pc_low = rd_data;
            next_state  = RWX_ST_HIGH;
         end
         RWX_ST_HIGH: begin
            next_state = RWX_ST_DONE;
         end
         RWX_ST_DONE: begin
            next_done  = 1'b1;
            next_ready = 1'b1;
            next_state = RWX_ST_READY;
         end
         default: begin
            next_state = RWX_ST_READY;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state  <= RWX_ST_READY;
         ready  <= 1'b0;
         done   <= 1'b0;
         is_isr <= 1'b0;
         pc_low <= 8'h00;
      end else begin
         state  <= next_state;
         ready  <= next_ready;
         done   <= next_done;
         is_isr <= next_is_isr;
         pc_low <= next_pc_low;
      end
   end

   always_comb begin
      next_pc = pc;
      next_sp = sp;
      if (push_take) begin
         next_sp = sp_add(sp, SP_W'(1));
      end
      if (ret_take) begin
         // sp drops by two first, the address is then read at the new sp
         next_sp = sp_add(sp, SP_W'(-SP_POP_STEP));
      end
      if (step_take) begin
         next_pc = pc_step(pc);   // only pc moves
      end
      if (ret_finish) begin
         next_pc = {rd_data, pc_low};   // resume caller or interrupted code
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pc <= PC_RESET;
         sp <= SP_RESET;
      end else begin
         pc <= next_pc;
         sp <= next_sp;
      end
   end

   always_comb begin
      next_flags     = flags_in;   // copy of the core flags; these ops never write them
      next_wdt_clear = step_take && (op == RWX_OP_WDCLEAR);   // restart watchdog count
      next_gie       = gie;
      if (gie_clear) begin
         next_gie = 1'b0;
      end
      if (ret_finish && is_isr) begin
         // only once the return completes; wins over a clear in the same cycle
         next_gie = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flags     <= FLAG_RESET;
         gie       <= 1'b0;
         wdt_clear <= 1'b0;
      end else begin
         flags     <= next_flags;
         gie       <= next_gie;
         wdt_clear <= next_wdt_clear;
      end
   end
endmodule : rwx_exec

// file: verification/rwx_exec_props.sv
/* assertions on rwx_exec ports.
 assumes one clock and async active-low reset. */
`timescale 1ns/1ps
module rwx_exec_props
   import rwx_pkg::*;
(
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        op_valid,
   input wire rwx_op_t     op,
   input wire logic        push_en,
   input wire logic [3:0]  flags_in,
   input wire logic        ready,
   input wire logic        done,
   input wire logic [15:0] pc,
   input wire logic [7:0]  sp,
   input wire logic [3:0]  flags,
   input wire logic        gie,
   input wire logic        wdt_clear
);
   // push wins over an op in the same cycle
   wire take = ready && op_valid && !push_en;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   ret_pop_a: assert property (
      take && op == RWX_OP_CALLEXIT |=> sp == $past(sp) - SP_POP_STEP && !ready) else $error("return pop");
   ret_time_a: assert property (
      take && op == RWX_OP_CALLEXIT |=> !done [*3] ##1 done && ready) else $error("return timing");
   isr_pop_a: assert property (
      take && op == RWX_OP_ISREXIT |=> sp == $past(sp) - SP_POP_STEP) else $error("isr pop");
   isr_gie_a: assert property (
      take && op == RWX_OP_ISREXIT |-> ##4 done && gie && ready) else $error("isr gie");
   idle_pc_a: assert property (
      take && op == RWX_OP_IDLE |=> done && !wdt_clear && pc == $past(pc) + PC_STEP) else $error("idle");
   wd_clear_a: assert property (
      take && op == RWX_OP_WDCLEAR |=> wdt_clear && done && pc == $past(pc) + PC_STEP) else $error("wd");
   wd_cause_a: assert property (
      wdt_clear |-> $past(op) == RWX_OP_WDCLEAR && $past(op_valid)) else $error("wd cause");
   flag_hold_a: assert property (
      rstn |=> flags == $past(flags_in)) else $error("flags");
endmodule : rwx_exec_props
bind rwx_exec rwx_exec_props props_inst (.clock, .rstn, .op_valid, .op, .push_en, .flags_in, .ready,
   .done, .pc, .sp, .flags, .gie, .wdt_clear);

// file: verification/rwx_exec_tb.sv
/* bench for rwx_exec: op table, then pushes, both returns, refused op.
 assumes rwx_exec_props is bound to the design. */
`timescale 1ns/1ps
module rwx_exec_tb;
   import rwx_pkg::*;
   logic        clock = 0, rstn = 0, op_valid = 0, push_en = 0, gie_clear = 0;
   rwx_op_t     op = RWX_OP_NONE;
   logic [7:0]  push_data = 8'h00;
   logic [3:0]  flags_in = 4'h0;
   logic        ready, done, gie, wdt_clear;
   logic [15:0] pc, p;
   logic [7:0]  sp;
   logic [3:0]  flags;
   int          failures = 0, check_count = 0;
   rwx_op_t     row_op [4] = '{RWX_OP_IDLE, RWX_OP_WDCLEAR, RWX_OP_WDCLEAR, RWX_OP_IDLE};
   logic [3:0]  row_fl [4] = '{4'hF, 4'h5, 4'hA, 4'h0};
   logic        row_wd [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   rwx_exec rwx_exec_inst (.clock(clock), .rstn(rstn), .op_valid(op_valid), .op(op), .push_en(push_en),
      .push_data(push_data), .flags_in(flags_in), .gie_clear(gie_clear), .ready(ready), .done(done),
      .pc(pc), .sp(sp), .flags(flags), .gie(gie), .wdt_clear(wdt_clear));
   initial forever #20 clock = ~clock;
   task chk(string n, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (e !== g) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task close_out;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   task issue(rwx_op_t o);
      @(posedge clock);
      op_valid <= 1'b1;
      op <= o;
      @(posedge clock);
      op_valid <= 1'b0;
      #1;
   endtask : issue
   task push(logic [7:0] b);
      @(posedge clock);
      push_en <= 1'b1;
      push_data <= b;
   endtask : push
   task ret(rwx_op_t o, logic [15:0] e_pc, logic [7:0] e_sp, logic e_gie);
      issue(o);
      @(posedge clock);
      // idle while busy must be dropped
      op_valid <= 1'b1;
      op <= RWX_OP_IDLE;
      @(posedge clock);
      op_valid <= 1'b0;
      for (int i = 0; i < 6 && done !== 1'b1; i++) @(posedge clock) #1;
      chk("done", 1'b1, done);
      chk("pc", e_pc, pc);
      chk("sp", e_sp, sp);
      chk("gie", e_gie, gie);
      chk("flags", 4'hF, flags);
      @(posedge clock) #1;
      chk("done", 1'b0, done);
      chk("pc", e_pc, pc);
   endtask : ret
   initial begin
      repeat (6) @(posedge clock);
      chk("pc", 16'h0000, pc);
      chk("ready", 1'b0, ready);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         p = pc;
         @(posedge clock);
         flags_in <= row_fl[i];
         issue(row_op[i]);
         chk("pc", p + 16'h0001, pc);
         chk("wdt_clear", row_wd[i], wdt_clear);
         chk("sp", 8'h00, sp);
         chk("flags", row_fl[i], flags);
      end
      push(8'h34);
      flags_in <= 4'hF;
      push(8'h12);
      push(8'hCD);
      push(8'hAB);
      @(posedge clock);
      push_en <= 1'b0;
      ret(RWX_OP_ISREXIT, 16'hABCD, 8'h02, 1'b1);
      @(posedge clock);
      gie_clear <= 1'b1;
      @(posedge clock);
      gie_clear <= 1'b0;
      ret(RWX_OP_CALLEXIT, 16'h1234, 8'h00, 1'b0);
      // mid-run reset
      @(posedge clock);
      rstn <= 1'b0;
      @(posedge clock);
      rstn <= 1'b1;
      #1;
      chk("pc", PC_RESET, pc);
      chk("flags", FLAG_RESET, flags);
      chk("ready", 1'b0, ready);
      @(posedge clock) #1;
      chk("ready", 1'b1, ready);
      chk("sp", SP_RESET, sp);
      close_out;
   end
   // run needs under 100 cycles
   initial begin
      repeat (400) @(posedge clock);
      failures++;
      close_out;
   end
endmodule : rwx_exec_tb
